// ### uie_consts.svh
// Constants for the UART interrupt-enable and line-status block.
// Assumes inclusion by the design modules.
`ifndef UIE_CONSTS_SVH
`define UIE_CONSTS_SVH
`define UIE_OFS_HOLD 3'h0
`define UIE_OFS_IENA 3'h1
`define UIE_OFS_ISTA 3'h2
`define UIE_OFS_LCTL 3'h3
`define UIE_OFS_MCTL 3'h4
`define UIE_OFS_LSTA 3'h5
`define UIE_OFS_MSTA 3'h6
`define UIE_OFS_SCRA 3'h7
`define UIE_LCR_ENH 8'hbf
`define UIE_LCR_DIV 7
`define UIE_EFR_ENH 4
`define UIE_IER_RX 0
`define UIE_IER_TX 1
`define UIE_IER_LS 2
`define UIE_IER_MS 3
`define UIE_ISR_NONE 8'h01
`define UIE_ISR_LS 6'h06
`define UIE_ISR_RX 6'h04
`define UIE_ISR_TX 6'h02
`define UIE_ISR_MS 6'h00
`define UIE_RST_IER 8'h00
`define UIE_RST_LCR 8'h00
`define UIE_REV_CODE 8'h01
`define UIE_DEV_CODE 8'h5a
`endif

// ### uie_pkg.sv
// Types for the UART interrupt-enable and line-status block.
// Assumes the constants header is on the include path.
package uie_pkg;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [2:0] addr;
      logic [7:0] wdata;
   } uie_bus_type;
   typedef struct packed {
      logic push;
      logic push_err;
      logic pop;
      logic [5:0] level;
      logic head_brk;
      logic head_frm;
      logic head_par;
      logic overrun;
      logic any_err;
   } uie_rx_type;
endpackage : uie_pkg

// ### uie_lsr.sv
// Line status assembly and line-status interrupt latch.
// Assumes receive events are one-cycle pulses in the clock domain.
`timescale 1ns/1ps
`include "uie_consts.svh"
module uie_lsr
   import uie_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Sources
   input wire uie_rx_type rx,
   input wire logic thr_empty,
   input wire logic tsr_empty,
   input wire logic lsr_read,
   // Results
   output logic [7:0] lsr,
   output logic ls_pend
);
   typedef struct packed {
      logic dr;
      logic oe;
      logic pend;
   } uie_lsr_st_type;
   uie_lsr_st_type st_q, st_d;
   logic head_err;
   assign head_err = rx.head_brk | rx.head_frm | rx.head_par;
   always_comb begin
      st_d = st_q;
      if (rx.pop && rx.level == 6'h01 && !rx.push) begin
         st_d.dr = 1'b0;
      end
      if (rx.push) begin
         st_d.dr = 1'b1;
      end
      if (lsr_read) begin
         st_d.oe = 1'b0;
         st_d.pend = 1'b0;
      end
      if (rx.overrun) begin
         st_d.oe = 1'b1;
         st_d.pend = 1'b1;
      end
      if (rx.pop && rx.level > 6'h01 && rx.push_err) begin
         st_d.pend = 1'b1;
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end
   // Head errors are live status; overrun pulse raises interrupt on the next clock
   assign lsr = {rx.any_err, thr_empty & tsr_empty, thr_empty, rx.head_brk,
                 rx.head_frm, rx.head_par, st_q.oe, st_q.dr};
   assign ls_pend = st_q.pend | (head_err & st_q.dr);
   property p_dr_set;
      @(posedge clk) disable iff (rst) (ce && rx.push) |=> lsr[0];
   endproperty
   a_dr_set: assert property (p_dr_set) else $error("data ready not set on push");
   property p_oe_set;
      @(posedge clk) disable iff (rst) (ce && rx.overrun) |=> (lsr[1] && ls_pend);
   endproperty
   a_oe_set: assert property (p_oe_set) else $error("overrun not reported");
   property p_temt;
      @(posedge clk) disable iff (rst) lsr[6] |-> lsr[5];
   endproperty
   a_temt: assert property (p_temt) else $error("shift empty without holding empty");
endmodule : uie_lsr

// ### uie_top.sv
// One UART channel: interrupt enable, status, line status and register port.
// Assumes the serial engines and FIFOs sit outside and drive the receive/transmit status.
`timescale 1ns/1ps
`include "uie_consts.svh"
module uie_top
   import uie_pkg::*;
#(
   parameter logic [7:0] REV_CODE = `UIE_REV_CODE, // Arbitrary value
   parameter logic [7:0] DEV_CODE = `UIE_DEV_CODE  // Arbitrary value
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Register port
   input wire uie_bus_type bus,
   output logic [7:0] rdata,
   // Receive path status
   input wire uie_rx_type rx,
   input wire logic [7:0] rx_data,
   input wire logic rx_timeout,
   // Transmit path status
   input wire logic thr_empty,
   input wire logic tsr_empty,
   input wire logic tx_below_trig,
   // Modem status
   input wire logic [7:0] modem_status,
   // FIFO configuration from the FIFO control logic
   input wire logic fifo_en,
   input wire logic [5:0] rx_trig,
   // Outputs
   output logic thr_wr,
   output logic [7:0] thr_data,
   output logic irq,
   output logic polled_mode
);
   typedef struct packed {
      logic [7:0] interrupt_enable;
      logic [7:0] line_control;
      logic [7:0] enhanced_function;
      logic [7:0] dll;
      logic [7:0] divisor_high;
      logic [7:0] divisor_fraction;
      logic [7:0] scratch_pad;
      logic [7:0] flow_resume_char_1;
      logic [7:0] flow_resume_char_2;
      logic [7:0] flow_pause_char_1;
      logic [7:0] flow_pause_char_2;
      logic tx_pend;
      logic thr_wr;
      logic [7:0] thr_data;
      logic [7:0] rdata;
   } uie_state_type;
   uie_state_type s_q, s_d;
   logic [7:0] lsr;
   logic ls_pend;
   logic enh, div, rx_src, tx_src, ms_src;
   logic [5:0] isr_code;
   logic [7:0] interrupt_status;
   uie_lsr u_lsr (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .rx(rx),
      .thr_empty(thr_empty),
      .tsr_empty(tsr_empty),
      .lsr_read(ce && bus.rd && !enh && !div && bus.addr == `UIE_OFS_LSTA),
      .lsr(lsr),
      .ls_pend(ls_pend)
   );
   assign enh = (s_q.line_control == `UIE_LCR_ENH);
   assign div = s_q.line_control[`UIE_LCR_DIV] & !enh;
   // Data-ready source: trigger level in FIFO mode, holding full otherwise
   assign rx_src = s_q.interrupt_enable[`UIE_IER_RX] & (fifo_en ? (rx.level >= rx_trig) : lsr[0]);
   assign tx_src = s_q.interrupt_enable[`UIE_IER_TX] & s_q.tx_pend;
   assign ms_src = s_q.interrupt_enable[`UIE_IER_MS] & |modem_status[3:0];
   always_comb begin
      isr_code = `UIE_ISR_MS;
      if (s_q.interrupt_enable[`UIE_IER_LS] && ls_pend) begin
         isr_code = `UIE_ISR_LS;
      end else if (s_q.interrupt_enable[`UIE_IER_RX] && rx_timeout && fifo_en) begin
         isr_code = 6'h0c;
      end else if (rx_src) begin
         isr_code = `UIE_ISR_RX;
      end else if (tx_src) begin
         isr_code = `UIE_ISR_TX;
      end
   end
   assign irq = (s_q.interrupt_enable[`UIE_IER_LS] & ls_pend) | rx_src | tx_src | ms_src |
                (s_q.interrupt_enable[`UIE_IER_RX] & rx_timeout & fifo_en);
   assign interrupt_status = irq ? {fifo_en, fifo_en, isr_code} : {fifo_en, fifo_en, 6'h01};
   assign polled_mode = fifo_en && s_q.interrupt_enable[3:0] == 4'h0;
   always_comb begin
      s_d = s_q;
      s_d.thr_wr = 1'b0;
      // Transmit-ready latch: holding empty (and below trigger in FIFO mode) sets, status read showing it or holding write clears
      if (bus.rd && !enh && bus.addr == `UIE_OFS_ISTA && isr_code == `UIE_ISR_TX) begin
         s_d.tx_pend = 1'b0;
      end
      if (bus.wr && !div && !enh && bus.addr == `UIE_OFS_HOLD) begin
         s_d.tx_pend = 1'b0;
         s_d.thr_wr = 1'b1;
         s_d.thr_data = bus.wdata;
      end
      if (bus.wr && !div && !enh && bus.addr == `UIE_OFS_IENA && bus.wdata[`UIE_IER_TX] &&
          !s_q.interrupt_enable[`UIE_IER_TX] && thr_empty) begin
         s_d.tx_pend = 1'b1;
      end
      if (fifo_en ? tx_below_trig : thr_empty) begin
         if (!(bus.wr && bus.addr == `UIE_OFS_HOLD && !div && !enh)) begin
            s_d.tx_pend = s_d.tx_pend | (thr_empty && !s_q.thr_wr);
         end
      end
      if (bus.wr) begin
         unique case (bus.addr)
            `UIE_OFS_HOLD: begin
               if (div) s_d.dll = bus.wdata;
            end
            `UIE_OFS_IENA: begin
               if (div) begin
                  s_d.divisor_high = bus.wdata;
               end else if (!enh) begin
                  s_d.interrupt_enable = s_q.enhanced_function[`UIE_EFR_ENH] ? bus.wdata : {4'h0, bus.wdata[3:0]};
               end
            end
            `UIE_OFS_ISTA: begin
               if (enh) begin
                  s_d.enhanced_function = bus.wdata;
               end else if (div && s_q.enhanced_function[`UIE_EFR_ENH]) begin
                  s_d.divisor_fraction = {2'h0, bus.wdata[5:0]};
               end
            end
            `UIE_OFS_LCTL: s_d.line_control = bus.wdata;
            `UIE_OFS_MCTL: begin
               if (enh) s_d.flow_resume_char_1 = bus.wdata;
            end
            `UIE_OFS_LSTA: begin
               if (enh) s_d.flow_resume_char_2 = bus.wdata;
            end
            `UIE_OFS_MSTA: begin
               if (enh) s_d.flow_pause_char_1 = bus.wdata;
            end
            `UIE_OFS_SCRA: begin
               if (enh) s_d.flow_pause_char_2 = bus.wdata;
               else s_d.scratch_pad = bus.wdata;
            end
         endcase
      end
      s_d.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            `UIE_OFS_HOLD: begin
               if (div) s_d.rdata = (s_q.dll == 8'h00 && s_q.divisor_high == 8'h00) ? REV_CODE : s_q.dll;
               else if (!enh) s_d.rdata = rx_data;
            end
            `UIE_OFS_IENA: begin
               if (div) s_d.rdata = (s_q.dll == 8'h00 && s_q.divisor_high == 8'h00) ? DEV_CODE : s_q.divisor_high;
               else if (!enh) s_d.rdata = s_q.interrupt_enable;
            end
            `UIE_OFS_ISTA: begin
               if (enh) s_d.rdata = s_q.enhanced_function;
               else if (div && s_q.enhanced_function[`UIE_EFR_ENH]) s_d.rdata = s_q.divisor_fraction;
               else s_d.rdata = interrupt_status;
            end
            `UIE_OFS_LCTL: s_d.rdata = s_q.line_control;
            `UIE_OFS_MCTL: s_d.rdata = enh ? s_q.flow_resume_char_1 : 8'h00;
            `UIE_OFS_LSTA: s_d.rdata = enh ? s_q.flow_resume_char_2 : lsr;
            `UIE_OFS_MSTA: s_d.rdata = enh ? s_q.flow_pause_char_1 : modem_status;
            `UIE_OFS_SCRA: s_d.rdata = enh ? s_q.flow_pause_char_2 : s_q.scratch_pad;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.interrupt_enable <= `UIE_RST_IER;
         s_q.line_control <= `UIE_RST_LCR;
      end else if (ce) begin
         s_q <= s_d;
      end
   end
   assign rdata = s_q.rdata;
   assign thr_wr = s_q.thr_wr;
   assign thr_data = s_q.thr_data;
   property p_rx_trig;
      @(posedge clk) disable iff (rst)
         (fifo_en && s_q.interrupt_enable[0] && rx.level >= rx_trig) |-> irq;
   endproperty
   a_rx_trig: assert property (p_rx_trig) else $error("trigger level without interrupt");
   property p_mask;
      @(posedge clk) disable iff (rst) (s_q.interrupt_enable[3:0] == 4'h0) |-> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("interrupt while all masked");
   property p_polled;
      @(posedge clk) disable iff (rst) polled_mode |-> (interrupt_status[0] && interrupt_status[7:6] == 2'h3);
   endproperty
   a_polled: assert property (p_polled) else $error("polled mode shows pending");
   property p_nf_rx;
      @(posedge clk) disable iff (rst) (!fifo_en && s_q.interrupt_enable[0] && lsr[0]) |-> irq;
   endproperty
   a_nf_rx: assert property (p_nf_rx) else $error("holding full without interrupt");
   property p_tx_en;
      @(posedge clk) disable iff (rst)
         (ce && bus.wr && !div && !enh && bus.addr == 3'h1 && bus.wdata[1] && !s_q.interrupt_enable[1] && thr_empty)
         |=> irq;
   endproperty
   a_tx_en: assert property (p_tx_en) else $error("tx enable on empty no interrupt");
   property p_lsr_clr;
      @(posedge clk) disable iff (rst)
         (ce && bus.rd && !enh && !div && bus.addr == 3'h5 && !rx.overrun && !lsr[2] && !lsr[3] && !lsr[4]
          && !(rx.pop && rx.push_err)) |=> !ls_pend;
   endproperty
   a_lsr_clr: assert property (p_lsr_clr) else $error("line status read did not clear");
endmodule : uie_top

// ### uie_host.sv
// Host processor model for the parallel register port.
// Assumes one clock; requests are launched just after a rising edge.
`timescale 1ns/1ps
module uie_host
   import uie_pkg::*;
(
   // Clock
   input wire logic clk,
   // Register port
   output uie_bus_type bus,
   input wire logic [7:0] rdata
);
   initial bus = '0;
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk);
      bus <= '0;
      #1;
   endtask : wr
   // Read data is registered, so it is taken just after the sampling edge
   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge clk);
      bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge clk);
      bus <= '0;
      #1;
      d = rdata;
   endtask : rd
endmodule : uie_host

// ### test_uie_top.sv
// Self-checking bench for one UART channel's enables and line status.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module test_uie_top;
   import uie_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   uie_bus_type bus;
   uie_rx_type rx = '0;
   logic thr_empty = 1'b1;
   logic tsr_empty = 1'b1;
   logic fifo_en = 1'b0;
   logic [5:0] rx_trig = 6'h02;
   logic [7:0] ms = 8'h00;
   logic ce = 1'b1;
   logic rx_tmo = 1'b0;
   logic [7:0] rdata, thr_data, v;
   logic thr_wr, irq, polled_mode;
   int miscompares = 0;
   int comparisons = 0;
   always #5 clk = ~clk;
   uie_top #(.REV_CODE(8'h3c), .DEV_CODE(8'h7e)) i_uie_top (.clk(clk), .rst(rst), .ce(ce), .bus(bus),
      .rdata(rdata), .rx(rx), .rx_data(8'h5c), .rx_timeout(rx_tmo), .thr_empty(thr_empty), .tsr_empty(tsr_empty),
      .tx_below_trig(1'b0), .modem_status(ms), .fifo_en(fifo_en), .rx_trig(rx_trig), .thr_wr(thr_wr),
      .thr_data(thr_data), .irq(irq), .polled_mode(polled_mode));
   uie_host i_uie_host (.clk(clk), .bus(bus), .rdata(rdata));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic results;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : results
   task automatic tick;
      @(posedge clk);
      #1;
   endtask : tick
   initial begin
      #200000;
      miscompares++;
      results;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      i_uie_host.rd(3'h5, v); chk("line_status", v, 8'h60);
      i_uie_host.rd(3'h1, v); chk("interrupt_enable", v, 8'h00);
      i_uie_host.rd(3'h2, v); chk("interrupt_status", v, 8'h01);
      i_uie_host.wr(3'h7, 8'ha5);
      i_uie_host.rd(3'h7, v); chk("scratch_pad", v, 8'ha5);
      // Clock enable low freezes state, so this write must not land
      ce <= 1'b0;
      i_uie_host.wr(3'h7, 8'h5a);
      ce <= 1'b1;
      i_uie_host.rd(3'h7, v); chk("scratch_frozen", v, 8'ha5);
      i_uie_host.wr(3'h0, 8'h3c); chk("thr_wr", {7'h0, thr_wr}, 8'h01);
      chk("thr_data", thr_data, 8'h3c);
      i_uie_host.wr(3'h1, 8'h02); tick; chk("irq", {7'h0, irq}, 8'h01);
      i_uie_host.rd(3'h2, v); chk("interrupt_status", v, 8'h02);
      i_uie_host.wr(3'h1, 8'h00);
      // Divisor page: identity codes show when both divisor bytes are zero
      i_uie_host.wr(3'h3, 8'h80);
      i_uie_host.wr(3'h0, 8'h00);
      i_uie_host.wr(3'h1, 8'h00);
      i_uie_host.rd(3'h0, v); chk("device_revision", v, 8'h3c);
      i_uie_host.rd(3'h1, v); chk("device_identifier", v, 8'h7e);
      i_uie_host.wr(3'h3, 8'h00);
      @(posedge clk);
      fifo_en <= 1'b1;
      tsr_empty <= 1'b0;
      rx.push <= 1'b1;
      rx.level <= 6'h01;
      @(posedge clk);
      rx.push <= 1'b0;
      tick; chk("polled_mode", {7'h0, polled_mode}, 8'h01);
      i_uie_host.rd(3'h5, v); chk("line_status", v, 8'h21);
      chk("irq", {7'h0, irq}, 8'h00);
      i_uie_host.rd(3'h0, v); chk("receive_holding", v, 8'h5c);
      i_uie_host.wr(3'h1, 8'h01); tick; chk("irq", {7'h0, irq}, 8'h00);
      rx_tmo <= 1'b1;
      tick; chk("irq", {7'h0, irq}, 8'h01);
      i_uie_host.rd(3'h2, v); chk("interrupt_status", v, 8'hcc);
      rx_tmo <= 1'b0;
      rx.push <= 1'b1;
      rx.level <= 6'h02;
      @(posedge clk);
      rx.push <= 1'b0;
      tick; chk("irq", {7'h0, irq}, 8'h01);
      i_uie_host.rd(3'h2, v); chk("interrupt_status", v, 8'hc4);
      // Level is the fill before the pop; it drops after the pop is taken
      rx.pop <= 1'b1;
      @(posedge clk);
      rx.pop <= 1'b0;
      rx.level <= 6'h01;
      tick; chk("irq", {7'h0, irq}, 8'h00);
      i_uie_host.wr(3'h1, 8'h04);
      rx.overrun <= 1'b1;
      @(posedge clk);
      rx.overrun <= 1'b0;
      tick; chk("irq", {7'h0, irq}, 8'h01);
      i_uie_host.rd(3'h5, v); chk("line_status", v, 8'h23);
      tick; chk("irq", {7'h0, irq}, 8'h00);
      i_uie_host.wr(3'h1, 8'h00);
      rx.head_par <= 1'b1;
      rx.any_err <= 1'b1;
      i_uie_host.rd(3'h5, v); chk("line_status", v & 8'hfd, 8'ha5);
      rx.head_par <= 1'b0;
      rx.any_err <= 1'b0;
      rx.pop <= 1'b1;
      @(posedge clk);
      rx.pop <= 1'b0;
      rx.level <= 6'h00;
      i_uie_host.rd(3'h5, v); chk("data_ready", v & 8'h01, 8'h00);
      i_uie_host.wr(3'h1, 8'h08);
      ms <= 8'h01;
      tick; chk("irq", {7'h0, irq}, 8'h01);
      i_uie_host.rd(3'h6, v); chk("modem_status", v, 8'h01);
      results;
   end
endmodule : test_uie_top
